// ---- pkg/llcb_pkg.sv ----
// Package: widths, constants and state encoding for the load-line / current-balance PID block
package llcb_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int PHASES = 6;
    localparam int CUR_W = 8;
    localparam int ERR_W = 6;
    localparam int GAIN_W = 8;
    localparam int CODE_W = 6;
    localparam int OFS_W = 4;
    localparam int ACC_W = 20;
    localparam int COMP_W = 10;
    localparam int RAMP_W = 10;
    localparam int LPF_SHIFT = 3;
    localparam int BAL_SHIFT = 2;
    localparam int SUM_W = CUR_W + 3;
    // ------------------------------------------------------------
    // Setpoint: offset steps of 3.125 mV, at most 50 mV (16 steps)
    // ------------------------------------------------------------
    localparam real OFS_STEP_MV = 3.125;
    localparam real OFS_MAX_MV = 50.0;
    localparam logic [4:0] OFS_MAX_STEPS = 5'(int'(OFS_MAX_MV / OFS_STEP_MV));
    localparam logic [CODE_W-1:0] CODE_1V000 = 6'h23;
    localparam logic [CODE_W-1:0] CODE_OFF_A = 6'h3F;
    localparam logic [CODE_W-1:0] CODE_OFF_B = 6'h3E;
    // ------------------------------------------------------------
    // Timing: master oscillator and sampling clock
    // ------------------------------------------------------------
    localparam real MASTER_OSC_MHZ = 133.33;
    localparam real SYS_CLK_MHZ = 40.0;
    localparam int SERIAL_BITS = CUR_W;
    // ------------------------------------------------------------
    // Reset values, limits and state encoding
    // ------------------------------------------------------------
    localparam logic [COMP_W-1:0] COMP_RESET = 10'h000;
    localparam logic [RAMP_W-1:0] RAMP_RESET = 10'h000;
    localparam logic signed [ACC_W-1:0] ACC_MAX = 20'sh7FFFF;
    localparam logic signed [ACC_W-1:0] ACC_MIN = -20'sh80000;
    localparam logic [COMP_W-1:0] COMP_MAX = 10'h3FF;
    typedef enum logic [1:0] {
        ST_LOAD = 2'b00,
        ST_RUN = 2'b01,
        ST_BAL = 2'b10
    } llcb_state_t;
endpackage

// ---- core/llcb_serial_rx.sv ----
// Serial receiver: three-flop synchroniser and shift register for one current sample line
module llcb_serial_rx
    import llcb_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic serClk,
    input wire logic serData,
    input wire logic serFrame,
    output logic [llcb_pkg::CUR_W-1:0] sample,
    output logic sampleValid
);
    logic [2:0] clkSync_reg;
    logic [2:0] datSync_reg;
    logic [2:0] frmSync_reg;
    logic [CUR_W-1:0] shift_reg;
    logic [3:0] bitCnt_reg;
    logic clkLvl_reg;
    logic datLvl_reg;
    logic frmLvl_reg;
    // A level counts only once the second and third flops agree; idle levels are low
    wire clkAgree = clkSync_reg[1] == clkSync_reg[2];
    wire clkRise = clkAgree & clkSync_reg[2] & ~clkLvl_reg;
    wire datNow = (datSync_reg[1] == datSync_reg[2]) ? datSync_reg[2] : datLvl_reg;
    wire frmNow = (frmSync_reg[1] == frmSync_reg[2]) ? frmSync_reg[2] : frmLvl_reg;
    wire frameOn = frmNow;
    wire lastBit = bitCnt_reg == 4'(SERIAL_BITS - 1);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clkSync_reg <= 3'h0;
            datSync_reg <= 3'h0;
            frmSync_reg <= 3'h0;
            shift_reg <= '0;
            bitCnt_reg <= 4'h0;
            clkLvl_reg <= 1'b0;
            datLvl_reg <= 1'b0;
            frmLvl_reg <= 1'b0;
            sample <= '0;
            sampleValid <= 1'b0;
        end else begin
            clkLvl_reg <= clkAgree ? clkSync_reg[2] : clkLvl_reg;
            datLvl_reg <= datNow;
            frmLvl_reg <= frmNow;
            clkSync_reg <= {clkSync_reg[1:0], serClk};
            datSync_reg <= {datSync_reg[1:0], serData};
            frmSync_reg <= {frmSync_reg[1:0], serFrame};
            sampleValid <= 1'b0;
            if (!frameOn) begin
                bitCnt_reg <= 4'h0;
            end else if (clkRise) begin
                // Msb first; the word is taken when the last bit arrives
                shift_reg <= {shift_reg[CUR_W-2:0], datNow};
                bitCnt_reg <= lastBit ? 4'h0 : bitCnt_reg + 4'h1;
                if (lastBit) begin
                    sample <= {shift_reg[CUR_W-2:0], datNow};
                    sampleValid <= 1'b1;
                end
            end
        end
    end
endmodule

// ---- core/llcb_controller.sv ----
// Load-line, current balance and PID compensator for a six-phase digital PWM
// Summary of operation
// - Sum phase currents, scale by load-line gain, low-pass filter, add to error.
// - Setpoint offset 0 to 46.875 mV in 3.125 mV steps (4-bit input, 15 steps at most).
// - Load-line slope programmed separately from the offset.
// - Setpoint chosen by a 5- or 6-bit voltage code.
// - Code 100011 selects 1.000 V at zero load.
// - All loop timing comes from one master oscillator.
// - Average current is the sum of active channels over their count.
// - Imbalance is sample minus average, filtered, corrects that channel.
// - Corrected level compared with a sawtooth ramp gives pulse width.
// - PID terms weighted by three gains form the compensation.
// - Gains come from nonvolatile storage, loaded right after reset release.
// - Compensation drives a six-phase digital pulse width modulator.
module llcb_controller
    import llcb_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [llcb_pkg::PHASES-1:0] curSerClk,
    input wire logic [llcb_pkg::PHASES-1:0] curSerData,
    input wire logic [llcb_pkg::PHASES-1:0] curSerFrame,
    input wire logic [llcb_pkg::PHASES-1:0] phaseActive,
    input wire logic signed [llcb_pkg::ERR_W-1:0] errorWord,
    input wire logic errorValid,
    input wire logic [llcb_pkg::CODE_W-1:0] voltageSetpointCode,
    input wire logic codeSixBit,
    input wire logic [llcb_pkg::OFS_W-1:0] loadLineOffset,
    input wire logic [llcb_pkg::GAIN_W-1:0] loadLineGain,
    input wire logic [llcb_pkg::GAIN_W-1:0] nvProportionalGain,
    input wire logic [llcb_pkg::GAIN_W-1:0] nvIntegralGain,
    input wire logic [llcb_pkg::GAIN_W-1:0] nvDerivativeGain,
    output logic [llcb_pkg::PHASES-1:0] pulseOut,
    output logic [llcb_pkg::COMP_W-1:0] compLevel,
    output logic [llcb_pkg::CODE_W-1:0] targetCode,
    output logic [4:0] targetOffsetSteps,
    output logic outputOff,
    output logic [llcb_pkg::CUR_W-1:0] averagePhaseCurrent,
    output logic gainsLoaded
);
    // ------------------------------------------------------------
    // Types, state and storage
    // ------------------------------------------------------------
    typedef logic signed [ACC_W-1:0] llcb_acc_t;
    llcb_state_t state_reg;
    logic [GAIN_W-1:0] proportionalGain_reg;
    logic [GAIN_W-1:0] integralGain_reg;
    logic [GAIN_W-1:0] derivativeGain_reg;
    logic [CUR_W-1:0] sampleHold_reg [PHASES];
    logic [PHASES-1:0] sampleSeen_reg;
    llcb_acc_t loadLineFilt_reg;
    llcb_acc_t integ_reg;
    llcb_acc_t prevErr_reg;
    logic signed [ACC_W-1:0] balFilt_reg [PHASES];
    logic [RAMP_W-1:0] ramp_reg;
    logic [CUR_W-1:0] sample [PHASES];
    logic [PHASES-1:0] sampleValid;

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    function automatic llcb_acc_t sat_add(input llcb_acc_t a, input llcb_acc_t b);
        logic signed [ACC_W:0] s;
        s = {a[ACC_W-1], a} + {b[ACC_W-1], b};
        if (s > (ACC_W+1)'(ACC_MAX)) sat_add = ACC_MAX;
        else if (s < (ACC_W+1)'(ACC_MIN)) sat_add = ACC_MIN;
        else sat_add = s[ACC_W-1:0];
    endfunction

    function automatic logic [COMP_W-1:0] to_level(input llcb_acc_t v);
        llcb_acc_t sh;
        sh = v >>> 4;
        if (sh < 0) to_level = '0;
        else if (sh > llcb_acc_t'(COMP_MAX)) to_level = COMP_MAX;
        else to_level = sh[COMP_W-1:0];
    endfunction

    // ------------------------------------------------------------
    // Serial receivers, one per phase
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < PHASES; g++) begin : gRx
            llcb_serial_rx uRx (
                .sys_clk(sys_clk),
                .rst(rst),
                .serClk(curSerClk[g]),
                .serData(curSerData[g]),
                .serFrame(curSerFrame[g]),
                .sample(sample[g]),
                .sampleValid(sampleValid[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Setpoint decode
    // ------------------------------------------------------------
    // In 5-bit mode the extra low bit is forced to one; code 100011 means 1.000 V
    wire [CODE_W-1:0] codeEff = codeSixBit ? voltageSetpointCode : {voltageSetpointCode[5:1], 1'b1};
    wire codeIsOff = (codeEff == CODE_OFF_A) || (codeEff == CODE_OFF_B);
    wire [4:0] ofsSteps = {1'b0, loadLineOffset} > OFS_MAX_STEPS ? OFS_MAX_STEPS : {1'b0, loadLineOffset};

    // ------------------------------------------------------------
    // Sum of all channels, sum and average of active channels
    // ------------------------------------------------------------
    logic [SUM_W-1:0] activeSum;
    logic [SUM_W-1:0] totalSum;
    logic [2:0] activeCount;
    always_comb begin
        activeSum = '0;
        totalSum = '0;
        activeCount = 3'h0;
        for (int i = 0; i < PHASES; i++) begin
            totalSum = totalSum + SUM_W'(sampleHold_reg[i]);
            if (phaseActive[i]) begin
                activeSum = activeSum + SUM_W'(sampleHold_reg[i]);
                activeCount = activeCount + 3'h1;
            end
        end
    end
    // Division by a small count; a divider is cheap here and avoids a reciprocal table
    wire [SUM_W-1:0] avgWide = activeCount == 3'h0 ? '0 : activeSum / SUM_W'(activeCount);
    wire [CUR_W-1:0] avgCur = avgWide[CUR_W-1:0];
    wire allSeen = (sampleSeen_reg & phaseActive) == phaseActive && phaseActive != '0;

    // ------------------------------------------------------------
    // Load line term and PID
    // ------------------------------------------------------------
    wire llcb_acc_t loadLineRaw = llcb_acc_t'(totalSum) * llcb_acc_t'({1'b0, loadLineGain});
    wire llcb_acc_t loadLineStep = (loadLineRaw - loadLineFilt_reg) >>> LPF_SHIFT;
    wire llcb_acc_t ofsTerm = llcb_acc_t'({1'b0, ofsSteps}) <<< 4;
    wire llcb_acc_t errEff = (llcb_acc_t'(errorWord) <<< 4) + (loadLineFilt_reg >>> 4) + ofsTerm;
    wire llcb_acc_t pTerm = errEff * llcb_acc_t'({1'b0, proportionalGain_reg});
    wire llcb_acc_t iStep = errEff * llcb_acc_t'({1'b0, integralGain_reg});
    wire llcb_acc_t dTerm = (errEff - prevErr_reg) * llcb_acc_t'({1'b0, derivativeGain_reg});
    wire llcb_acc_t integNext = sat_add(integ_reg, iStep >>> 4);
    wire llcb_acc_t pidSum = sat_add(sat_add(pTerm, integNext), dTerm);
    wire [COMP_W-1:0] compNext = to_level(pidSum);

    // ------------------------------------------------------------
    // Control state and loop registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= ST_LOAD;
            proportionalGain_reg <= '0;
            integralGain_reg <= '0;
            derivativeGain_reg <= '0;
            gainsLoaded <= 1'b0;
        end else begin
            case (state_reg)
                ST_LOAD: begin
                    // Gains taken from nonvolatile storage right after reset release
                    proportionalGain_reg <= nvProportionalGain;
                    integralGain_reg <= nvIntegralGain;
                    derivativeGain_reg <= nvDerivativeGain;
                    gainsLoaded <= 1'b1;
                    state_reg <= ST_RUN;
                end
                ST_RUN: state_reg <= allSeen ? ST_BAL : ST_RUN;
                ST_BAL: state_reg <= ST_RUN;
                default: state_reg <= ST_LOAD;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            loadLineFilt_reg <= '0;
            integ_reg <= '0;
            prevErr_reg <= '0;
            compLevel <= COMP_RESET;
        end else if (errorValid && state_reg != ST_LOAD) begin
            loadLineFilt_reg <= loadLineFilt_reg + loadLineStep;
            integ_reg <= integNext;
            prevErr_reg <= errEff;
            compLevel <= compNext;
        end
    end

    // ------------------------------------------------------------
    // Per-phase sample capture, balance filter and ramp compare
    // ------------------------------------------------------------
    generate
        for (g = 0; g < PHASES; g++) begin : gPh
            wire signed [ACC_W-1:0] imbalance = ACC_W'(sampleHold_reg[g]) - ACC_W'(avgCur);
            wire signed [ACC_W-1:0] balStep = (imbalance - balFilt_reg[g]) >>> BAL_SHIFT;
            wire signed [ACC_W-1:0] corrected = llcb_acc_t'({1'b0, compLevel}) - (balFilt_reg[g] <<< 2);
            wire [COMP_W-1:0] phaseLevel = to_level(corrected <<< 4);
            // Each phase ramp is staggered by one sixth of the period
            wire [RAMP_W-1:0] phaseRamp = ramp_reg + RAMP_W'((g * (1 << RAMP_W)) / PHASES);
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    sampleHold_reg[g] <= '0;
                    sampleSeen_reg[g] <= 1'b0;
                    balFilt_reg[g] <= '0;
                    pulseOut[g] <= 1'b0;
                end else begin
                    if (sampleValid[g]) begin
                        sampleHold_reg[g] <= sample[g];
                    end
                    // A sample that lands in the balance cycle opens the next round
                    if (sampleValid[g]) begin
                        sampleSeen_reg[g] <= 1'b1;
                    end else if (state_reg == ST_BAL) begin
                        sampleSeen_reg[g] <= 1'b0;
                    end
                    if (state_reg == ST_BAL) begin
                        balFilt_reg[g] <= phaseActive[g] ? balFilt_reg[g] + balStep : '0;
                    end
                    pulseOut[g] <= phaseActive[g] && !codeIsOff && phaseLevel > phaseRamp;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Sawtooth ramp and status outputs
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ramp_reg <= RAMP_RESET;
            targetCode <= '0;
            targetOffsetSteps <= 5'h00;
            outputOff <= 1'b1;
            averagePhaseCurrent <= '0;
        end else begin
            ramp_reg <= ramp_reg + 10'h001;
            targetCode <= codeEff;
            targetOffsetSteps <= ofsSteps;
            outputOff <= codeIsOff;
            if (state_reg == ST_BAL) begin
                averagePhaseCurrent <= avgCur;
            end
        end
    end
endmodule

// ---- sim/llcb_controller_assertions.sv ----
// Checker: timing and value properties at the controller ports
module llcb_controller_assertions
    import llcb_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [llcb_pkg::PHASES-1:0] phaseActive,
    input wire logic errorValid,
    input wire logic [llcb_pkg::CODE_W-1:0] voltageSetpointCode,
    input wire logic codeSixBit,
    input wire logic [llcb_pkg::OFS_W-1:0] loadLineOffset,
    input wire logic [llcb_pkg::PHASES-1:0] pulseOut,
    input wire logic [llcb_pkg::COMP_W-1:0] compLevel,
    input wire logic [llcb_pkg::CODE_W-1:0] targetCode,
    input wire logic [4:0] targetOffsetSteps,
    input wire logic outputOff,
    input wire logic gainsLoaded
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    logic [5:0] effCode;
    // Five-bit mode reads bit0 as set
    assign effCode = codeSixBit ? voltageSetpointCode : (voltageSetpointCode | 6'h01);
    sequence s_released;
        !rst ##1 !rst ##1 !rst;
    endsequence
    property p_target;
        !$past(rst) |-> targetCode == $past(effCode);
    endproperty
    property p_off;
        !$past(rst) |-> outputOff == ($past(effCode) inside {6'h3E, 6'h3F});
    endproperty
    property p_code1v;
        codeSixBit && voltageSetpointCode == 6'h23 |=> targetCode == 6'h23 && !outputOff;
    endproperty
    property p_offset;
        !$past(rst) |-> targetOffsetSteps == {1'b0, $past(loadLineOffset)};
    endproperty
    property p_pulse_off;
        outputOff && $past(outputOff) |-> pulseOut == 6'h00;
    endproperty
    property p_pulse_idle;
        (pulseOut & ~($past(phaseActive) | $past(phaseActive, 2))) == 6'h00;
    endproperty
    property p_comp_hold;
        !$past(errorValid) && !$past(rst) |-> compLevel == $past(compLevel);
    endproperty
    property p_gains;
        s_released |-> gainsLoaded ##1 gainsLoaded;
    endproperty
    property p_reset;
        $fell(rst) |-> outputOff && compLevel == 10'h000 && pulseOut == 6'h00;
    endproperty
    a_target: assert property (p_target) else $error("target code wrong");
    a_off: assert property (p_off) else $error("off flag wrong");
    a_code1v: assert property (p_code1v) else $error("code 23 not taken");
    a_offset: assert property (p_offset) else $error("offset steps wrong");
    a_pulse_off: assert property (p_pulse_off) else $error("pulse while off");
    a_pulse_idle: assert property (p_pulse_idle) else $error("pulse on idle phase");
    a_comp_hold: assert property (p_comp_hold) else $error("level moved without error");
    a_gains: assert property (p_gains) else $error("gains not loaded");
    a_reset: assert property (p_reset) else $error("reset values wrong");
endmodule

bind llcb_controller llcb_controller_assertions chk_i (.sys_clk, .rst, .phaseActive, .errorValid,
    .voltageSetpointCode, .codeSixBit, .loadLineOffset, .pulseOut, .compLevel, .targetCode,
    .targetOffsetSteps, .outputOff, .gainsLoaded);

// ---- sim/llcb_stage_model.sv ----
// Power-stage model: one serial current word per phase per cycle
module llcb_stage_model
    import llcb_pkg::*;
(
    input wire logic sys_clk,
    input wire logic [47:0] words,
    input wire logic start,
    output logic busy,
    output logic [llcb_pkg::PHASES-1:0] serClk,
    output logic [llcb_pkg::PHASES-1:0] serData,
    output logic [llcb_pkg::PHASES-1:0] serFrame
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        busy = 1'b0;
        serClk = 6'h00;
        serData = 6'h15;
        serFrame = 6'h00;
        forever begin
            @(posedge sys_clk);
            if (start) begin
                busy <= 1'b1;
                serFrame <= 6'h3F;
                for (int b = 7; b >= 0; b--) begin
                    for (int p = 0; p < 6; p++) begin
                        serData[p] <= words[p * 8 + b];
                    end
                    repeat (4) @(posedge sys_clk);
                    // Slow edges keep the line at an eighth of the clock
                    serClk <= 6'h3F;
                    repeat (4) @(posedge sys_clk);
                    serClk <= 6'h00;
                end
                repeat (4) @(posedge sys_clk);
                serFrame <= 6'h00;
                // Released line must not keep showing the last bit
                serData <= ~serData;
                busy <= 1'b0;
            end
        end
    end
endmodule

// ---- sim/llcb_controller_tb.sv ----
// Testbench: directed scenarios for the controller
module llcb_controller_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import llcb_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] curSerClk, curSerData, curSerFrame;
    logic [5:0] phaseActive = 6'h3F;
    logic signed [5:0] errorWord = 6'h00;
    logic errorValid = 1'b0;
    logic [5:0] voltageSetpointCode = 6'h3F;
    logic codeSixBit = 1'b1;
    logic [3:0] loadLineOffset = 4'h0;
    logic [7:0] loadLineGain = 8'h04;
    logic [47:0] words = 48'h0;
    logic start = 1'b0;
    logic busy;
    logic [5:0] pulseOut, targetCode;
    logic [9:0] compLevel, lv;
    logic [4:0] targetOffsetSteps;
    logic [7:0] averagePhaseCurrent;
    logic outputOff, gainsLoaded;
    int nFail = 0;
    int totalChecks = 0;
    llcb_controller llcb_controller_i (.sys_clk(sys_clk), .rst(rst), .curSerClk(curSerClk),
        .curSerData(curSerData), .curSerFrame(curSerFrame), .phaseActive(phaseActive),
        .errorWord(errorWord), .errorValid(errorValid), .voltageSetpointCode(voltageSetpointCode),
        .codeSixBit(codeSixBit), .loadLineOffset(loadLineOffset), .loadLineGain(loadLineGain),
        .nvProportionalGain(8'h10), .nvIntegralGain(8'hFF), .nvDerivativeGain(8'h01),
        .pulseOut(pulseOut), .compLevel(compLevel), .targetCode(targetCode),
        .targetOffsetSteps(targetOffsetSteps), .outputOff(outputOff),
        .averagePhaseCurrent(averagePhaseCurrent), .gainsLoaded(gainsLoaded));
    llcb_stage_model llcb_stage_model_i (.sys_clk(sys_clk), .words(words), .start(start), .busy(busy),
        .serClk(curSerClk), .serData(curSerData), .serFrame(curSerFrame));
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        totalChecks++;
        if (got !== exp) begin
            nFail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic t_reset();
        #1;
        chk("outputOff", 16'h1, {15'h0, outputOff});
        chk("gainsLoaded", 16'h0, {15'h0, gainsLoaded});
        tick(2);
        #1;
        chk("gainsLoaded", 16'h1, {15'h0, gainsLoaded});
        $display("reset test done");
    endtask
    task automatic t_codes();
        // Each entry: six-bit flag, code, expected effective code, expected off flag
        logic [13:0] tab [5] = '{14'h31C6, 14'h3FFF, 14'h3F7D, 14'h1F7F, 14'h1146};
        for (int i = 0; i < 5; i++) begin
            tick(1);
            {codeSixBit, voltageSetpointCode} <= tab[i][13:7];
            tick(2);
            #1;
            chk("targetCode", {10'h0, tab[i][6:1]}, {10'h0, targetCode});
            chk("outputOff", {15'h0, tab[i][0]}, {15'h0, outputOff});
            if (tab[i][0]) chk("pulseOut", 16'h0000, {10'h0, pulseOut});
        end
        $display("code test done");
    endtask
    task automatic t_offset();
        for (int i = 0; i < 16; i++) begin
            tick(1);
            loadLineOffset <= 4'(i);
            tick(2);
            #1;
            chk("targetOffsetSteps", 16'(i), {11'h0, targetOffsetSteps});
        end
        $display("offset test done");
    endtask
    task automatic t_error();
        tick(1);
        errorWord <= 6'sh1F;
        errorValid <= 1'b1;
        tick(1);
        errorValid <= 1'b0;
        tick(3);
        #1;
        lv = compLevel;
        chk("compLevel step", 16'h03FF, {6'h0, lv});
        tick(8);
        #1;
        chk("compLevel hold", {6'h0, lv}, {6'h0, compLevel});
        tick(1);
        errorValid <= 1'b1;
        tick(120);
        errorValid <= 1'b0;
        tick(3);
        #1;
        chk("compLevel rail", 16'h03FF, {6'h0, compLevel});
        tick(1);
        errorWord <= 6'sh20;
        errorValid <= 1'b1;
        tick(240);
        errorValid <= 1'b0;
        tick(3);
        #1;
        chk("compLevel other rail", 16'h0000, {6'h0, compLevel});
        $display("error test done");
    endtask
    task automatic t_balance(input logic [5:0] act, input logic [7:0] exp);
        tick(1);
        phaseActive <= act;
        words <= 48'h3C32281E140A;
        start <= 1'b1;
        tick(1);
        start <= 1'b0;
        tick(2);
        repeat (200) if (busy) tick(1);
        chk("busy", 16'h0000, {15'h0, busy});
        tick(12);
        #1;
        chk("averagePhaseCurrent", {8'h0, exp}, {8'h0, averagePhaseCurrent});
        $display("balance test done");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", totalChecks, nFail);
        if (nFail == 0 && totalChecks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #750000;
        nFail++;
        tally_and_finish();
    end
    initial begin
        tick(3);
        rst <= 1'b0;
        t_reset();
        t_codes();
        t_offset();
        t_error();
        t_balance(6'h3F, 8'h23);
        t_balance(6'h07, 8'h14);
        tally_and_finish();
    end
endmodule
